/* hw/fsw_params.svh */
// Purpose: constants of the flash status and write gate
// Assumes: opcodes are eight bits, addresses 24 bits
// Notes:   status field positions, opcodes, protection decode
`ifndef FSW_PARAMS_SVH
`define FSW_PARAMS_SVH

// ****************************************
// status word layout
// ****************************************
`define FSW_BIT_BUSY       0
`define FSW_BIT_WEL        1
`define FSW_BIT_BP_LO      2
`define FSW_BIT_BP_HI      5
`define FSW_BIT_QE         6
`define FSW_BIT_LOCK       7
`define FSW_STATUS_RESET   8'h00
`define FSW_NV_RESET       6'h00

// ****************************************
// latch-gated opcodes
// ****************************************
`define FSW_OP_PAGE_PROG   8'h02
`define FSW_OP_QPROG_A     8'h32
`define FSW_OP_QPROG_B     8'h38
`define FSW_OP_SECT_A      8'hd7
`define FSW_OP_SECT_B      8'h20
`define FSW_OP_HALF_BLK    8'h52
`define FSW_OP_BLK         8'hd8
`define FSW_OP_CHIP_A      8'hc7
`define FSW_OP_CHIP_B      8'h60
`define FSW_OP_STAT_WR     8'h01
`define FSW_OP_FUNC_WR     8'h42
`define FSW_OP_RDP_NV      8'h65
`define FSW_OP_ERDP_NV     8'h85
`define FSW_OP_IROW_ERASE  8'h64
`define FSW_OP_IROW_PROG   8'h62
`define FSW_OP_BOOT_WR     8'h15

// ****************************************
// protection decode
// ****************************************
`define FSW_BP_ALL_CODE    4'h9
`define FSW_BLK_MSB        23
`define FSW_BLK_LSB        16

`endif

/* hw/fsw_pkg.sv */
// Purpose: types shared by the flash status and write gate
// Assumes: constants come from fsw_params.svh
// Notes:   nothing is imported; users write fsw_pkg::name
package fsw_pkg;

  // ****************************************
  // operation sequencer, gray along idle-busy-suspended
  // ****************************************
  typedef enum logic [1:0] {
    FSW_IDLE = 2'b00,
    FSW_BUSY = 2'b01,
    FSW_SUSP = 2'b11
  } fsw_state_e;

  // operation target size handed to the array or register engine
  typedef enum logic [2:0] {
    FSW_SPAN_NONE   = 3'h0,
    FSW_SPAN_PAGE   = 3'h1,
    FSW_SPAN_SECTOR = 3'h2,
    FSW_SPAN_HALF   = 3'h3,
    FSW_SPAN_BLOCK  = 3'h4,
    FSW_SPAN_CHIP   = 3'h5,
    FSW_SPAN_REG    = 3'h6
  } fsw_span_e;

  // one decoded command from the serial front end
  typedef struct packed {
    logic        valid;
    logic [7:0]  opcode;
    logic [23:0] addr;
    logic [7:0]  data;
  } fsw_cmd_s;

  // command started toward the array or register engine
  typedef struct packed {
    logic        valid;
    logic [7:0]  opcode;
    logic [23:0] base;
    fsw_span_e   span;
  } fsw_exec_s;

endpackage : fsw_pkg

/* hw/flash_status_write_gate.sv */
// Purpose: status word and write-enable gating of a serial flash
// Assumes: cmd arrives fully decoded, one-cycle valid, synchronous to clk
// Notes:   array engine may end an operation early through opAbort
`timescale 1ns/100ps
`include "fsw_params.svh"

module flash_status_write_gate #(
  parameter logic [7:0]  LATCH_SET_OP    = 8'h06,
  parameter logic [7:0]  LATCH_CLR_OP    = 8'h04,
  parameter logic [7:0]  STAT_RD_OP      = 8'h05,
  parameter logic [7:0]  FUNC_RD_OP      = 8'h48,
  parameter logic [7:0]  EXT_RD_OP       = 8'h81,
  parameter logic [7:0]  VOL_RDP_OP      = 8'hc0,
  parameter logic [7:0]  VOL_ERDP_OP     = 8'h83,
  parameter logic [7:0]  SUSPEND_OP      = 8'h75,
  parameter logic [7:0]  RESUME_OP       = 8'h7a,
  parameter logic [7:0]  SW_RESET_OP     = 8'h99,
  parameter logic [23:0] PROG_CYCLES     = 24'd20,
  parameter logic [23:0] SECT_CYCLES     = 24'd40,
  parameter logic [23:0] BLOCK_CYCLES    = 24'd80,
  parameter logic [23:0] CHIP_CYCLES     = 24'd160,
  parameter logic [23:0] REG_CYCLES      = 24'd30
) (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire fsw_pkg::fsw_cmd_s  cmd,
  input  wire logic               writeProtectN,
  input  wire logic               bottomSelect,
  input  wire logic               opAbort,
  output logic [7:0]              statusWord,
  output logic                    quadIoEnable,
  output logic                    statusReadValid,
  output logic [7:0]              statusReadData,
  output fsw_pkg::fsw_exec_s      exec,
  output logic                    cmdRefused
);

  // ****************************************
  // state
  // ****************************************
  fsw_pkg::fsw_state_e  opState_r;
  logic                 writeInProgress_r;
  logic                 writeEnableLatch_r;
  logic [3:0]           blockProtectCode_r;
  logic                 quadIoEnable_r;
  logic                 statusWriteLock_r;
  logic [23:0]          opTimer_r;
  logic                 opIsRegWrite_r;
  logic                 statusReadValid_r;
  logic [7:0]           statusReadData_r;
  fsw_pkg::fsw_exec_s   exec_r;
  logic                 cmdRefused_r;

  // ****************************************
  // decode
  // ****************************************
  logic                 isGated;
  logic                 isRegWrite;
  logic                 busyOk;
  logic                 addrProtected;
  logic                 statusLocked;
  logic                 chipBlocked;
  logic                 targetBlocked;
  logic                 startOp;
  logic                 opEnds;
  logic [23:0]          opLength;
  fsw_pkg::fsw_span_e   opSpan;
  logic [23:0]          opBase;
  logic [7:0]           blockIdx;
  logic [7:0]           protMask;
  logic                 cmdIdle;

  // opcodes refused unless the latch is set
  always_comb
  begin
    isGated    = 1'b0;
    isRegWrite = 1'b0;
    case (cmd.opcode)
      `FSW_OP_PAGE_PROG, `FSW_OP_QPROG_A, `FSW_OP_QPROG_B:
        isGated = 1'b1;
      `FSW_OP_SECT_A, `FSW_OP_SECT_B, `FSW_OP_HALF_BLK, `FSW_OP_BLK,
      `FSW_OP_CHIP_A, `FSW_OP_CHIP_B:
        isGated = 1'b1;
      `FSW_OP_STAT_WR, `FSW_OP_FUNC_WR, `FSW_OP_ERDP_NV:
      begin
        isGated    = 1'b1;
        isRegWrite = 1'b1;
      end
      `FSW_OP_RDP_NV, `FSW_OP_IROW_ERASE, `FSW_OP_IROW_PROG, `FSW_OP_BOOT_WR:
      begin
        isGated    = 1'b1;
        isRegWrite = (cmd.opcode != `FSW_OP_IROW_ERASE) &&
                     (cmd.opcode != `FSW_OP_IROW_PROG);
      end
      default:
        isGated = 1'b0;
    endcase
  end

  // commands that still pass while an operation runs
  assign busyOk = (cmd.opcode == STAT_RD_OP) || (cmd.opcode == FUNC_RD_OP) ||
                  (cmd.opcode == EXT_RD_OP) || (cmd.opcode == SW_RESET_OP) ||
                  ((cmd.opcode == SUSPEND_OP) && !opIsRegWrite_r);

  // length, span and aligned base of each operation
  always_comb
  begin
    opLength = REG_CYCLES;
    opSpan   = fsw_pkg::FSW_SPAN_REG;
    opBase   = cmd.addr;
    case (cmd.opcode)
      `FSW_OP_PAGE_PROG, `FSW_OP_QPROG_A, `FSW_OP_QPROG_B, `FSW_OP_IROW_PROG:
      begin
        opLength = PROG_CYCLES;
        opSpan   = fsw_pkg::FSW_SPAN_PAGE;
      end
      `FSW_OP_SECT_A, `FSW_OP_SECT_B, `FSW_OP_IROW_ERASE:
      begin
        opLength = SECT_CYCLES;
        opSpan   = fsw_pkg::FSW_SPAN_SECTOR;
        opBase   = {cmd.addr[23:12], 12'h000};
      end
      `FSW_OP_HALF_BLK:
      begin
        opLength = BLOCK_CYCLES;
        opSpan   = fsw_pkg::FSW_SPAN_HALF;
        opBase   = {cmd.addr[23:15], 15'h0000};
      end
      `FSW_OP_BLK:
      begin
        opLength = BLOCK_CYCLES;
        opSpan   = fsw_pkg::FSW_SPAN_BLOCK;
        opBase   = {cmd.addr[23:16], 16'h0000};
      end
      `FSW_OP_CHIP_A, `FSW_OP_CHIP_B:
      begin
        opLength = CHIP_CYCLES;
        opSpan   = fsw_pkg::FSW_SPAN_CHIP;
        opBase   = 24'h000000;
      end
      default:
      begin
        opLength = REG_CYCLES;
        opSpan   = fsw_pkg::FSW_SPAN_REG;
      end
    endcase
  end

  // ****************************************
  // protection decode
  // ****************************************
  // code n (1..8) protects 2^(n-1) 64K blocks at top or bottom; 9 and up all
  assign blockIdx = cmd.addr[`FSW_BLK_MSB:`FSW_BLK_LSB];

  genvar gb;
  generate
    for (gb = 0; gb < 8; gb++)
    begin : g_prot
      // bit gb of the block index must match the protected end when gb >= n-1
      assign protMask[gb] = ({1'b0, blockProtectCode_r} <= 5'(gb + 1)) ?
                            (blockIdx[gb] == !bottomSelect) : 1'b1;
    end
  endgenerate

  always_comb
  begin
    if (blockProtectCode_r == 4'h0)
      addrProtected = 1'b0;
    else if (blockProtectCode_r >= `FSW_BP_ALL_CODE)
      addrProtected = 1'b1;
    else
      addrProtected = &protMask;
  end

  assign chipBlocked   = (blockProtectCode_r != 4'h0);
  assign statusLocked  = statusWriteLock_r && !writeProtectN;
  assign targetBlocked = (opSpan == fsw_pkg::FSW_SPAN_CHIP) ? chipBlocked :
                         (opSpan == fsw_pkg::FSW_SPAN_REG) ?
                           ((cmd.opcode == `FSW_OP_STAT_WR) && statusLocked) :
                         addrProtected;

  assign cmdIdle = cmd.valid && (opState_r != fsw_pkg::FSW_BUSY);
  // a gated command starts only with the latch set and the target free
  // only from idle: a start while suspended would leave busy with no timer behind it
  assign startOp = cmd.valid && (opState_r == fsw_pkg::FSW_IDLE) && isGated &&
                   writeEnableLatch_r && !targetBlocked;
  assign opEnds  = (opState_r == fsw_pkg::FSW_BUSY) &&
                   ((opTimer_r == 24'h000001) || opAbort);

  // ****************************************
  // operation sequencer
  // ****************************************
  // suspend freezes the timer; resume picks it up where it stopped
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      opState_r      <= fsw_pkg::FSW_IDLE;
      opTimer_r      <= 24'h000000;
      opIsRegWrite_r <= 1'b0;
    end
    else if (cmd.valid && (cmd.opcode == SW_RESET_OP))
    begin
      opState_r <= fsw_pkg::FSW_IDLE;                     // reset may lose data
      opTimer_r <= 24'h000000;
    end
    else
    begin
      case (opState_r)
        fsw_pkg::FSW_IDLE:
          if (startOp)
          begin
            opState_r      <= fsw_pkg::FSW_BUSY;
            opTimer_r      <= (opLength == 24'h000000) ? 24'h000001 : opLength;
            opIsRegWrite_r <= isRegWrite;
          end
        fsw_pkg::FSW_BUSY:
          if (opEnds)
            opState_r <= fsw_pkg::FSW_IDLE;
          else if (cmd.valid && busyOk && (cmd.opcode == SUSPEND_OP))
            opState_r <= fsw_pkg::FSW_SUSP;
          else
            opTimer_r <= opTimer_r - 24'h000001;
        fsw_pkg::FSW_SUSP:
          if (cmd.valid && (cmd.opcode == RESUME_OP))
            opState_r <= fsw_pkg::FSW_BUSY;
        default:
          opState_r <= fsw_pkg::FSW_IDLE;
      endcase
    end
  end

  // busy flag follows the sequencer from start to end
  always_ff @(posedge clk)
  begin
    if (!resetn)
      writeInProgress_r <= 1'b0;
    else if (cmd.valid && (cmd.opcode == SW_RESET_OP))
      writeInProgress_r <= 1'b0;
    else if (startOp)
      writeInProgress_r <= 1'b1;
    else if (opEnds)
      writeInProgress_r <= 1'b0;
    else if ((opState_r == fsw_pkg::FSW_BUSY) && cmd.valid && busyOk &&
             (cmd.opcode == SUSPEND_OP))
      writeInProgress_r <= 1'b0;                          // ready while suspended
    else if ((opState_r == fsw_pkg::FSW_SUSP) && cmd.valid &&
             (cmd.opcode == RESUME_OP))
      writeInProgress_r <= 1'b1;
  end

  // ****************************************
  // write-enable latch
  // ****************************************
  // status write leaves the latch alone until its own operation finishes
  always_ff @(posedge clk)
  begin
    if (!resetn)
      writeEnableLatch_r <= 1'b0;
    else if (opEnds)
      writeEnableLatch_r <= 1'b0;
    else if (cmd.valid && (cmd.opcode == SW_RESET_OP))
      writeEnableLatch_r <= 1'b0;
    else if (cmdIdle && (cmd.opcode == LATCH_SET_OP))
      writeEnableLatch_r <= 1'b1;
    else if (cmdIdle && (cmd.opcode == LATCH_CLR_OP))
      writeEnableLatch_r <= 1'b0;
  end

  // ****************************************
  // non-volatile status bits
  // ****************************************
  // resetn stands for the factory state; a real part keeps these over power
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      blockProtectCode_r <= 4'h0;
      quadIoEnable_r     <= 1'b0;
      statusWriteLock_r  <= 1'b0;
    end
    else if (startOp && (cmd.opcode == `FSW_OP_STAT_WR))
    begin
      blockProtectCode_r <= cmd.data[`FSW_BIT_BP_HI:`FSW_BIT_BP_LO];
      quadIoEnable_r     <= cmd.data[`FSW_BIT_QE];
      statusWriteLock_r  <= cmd.data[`FSW_BIT_LOCK];
    end
  end

  // ****************************************
  // read answer and executed-command report
  // ****************************************
  // read answer carries the word as it stood when the opcode arrived
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      statusReadValid_r <= 1'b0;
      statusReadData_r  <= `FSW_STATUS_RESET;
    end
    else
    begin
      statusReadValid_r <= cmd.valid && (cmd.opcode == STAT_RD_OP);
      if (cmd.valid && (cmd.opcode == STAT_RD_OP))
        statusReadData_r <= statusWord;
    end
  end

  // started operations and volatile register writes go to the engines
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      exec_r       <= '0;
      cmdRefused_r <= 1'b0;
    end
    else
    begin
      exec_r.valid  <= startOp || (cmdIdle && ((cmd.opcode == VOL_RDP_OP) ||
                                             (cmd.opcode == VOL_ERDP_OP)));
      exec_r.opcode <= cmd.opcode;
      exec_r.base   <= opBase;
      exec_r.span   <= isGated ? opSpan : fsw_pkg::FSW_SPAN_NONE;
      cmdRefused_r  <= cmd.valid && (((opState_r == fsw_pkg::FSW_BUSY) && !busyOk) ||
                                     (isGated && !startOp));
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign statusWord = {statusWriteLock_r, quadIoEnable_r, blockProtectCode_r,
                       writeEnableLatch_r, writeInProgress_r};
  assign quadIoEnable    = quadIoEnable_r;
  assign statusReadValid = statusReadValid_r;
  assign statusReadData  = statusReadData_r;
  assign exec            = exec_r;
  assign cmdRefused      = cmdRefused_r;

endmodule : flash_status_write_gate

/* verification/fsw_host_model.sv */
// Purpose: host side that hands decoded commands to the write gate
// Assumes: tasks are entered just after a rising edge of clk
// Notes:   released fields toggle so a stale command never looks live
`timescale 1ns/100ps
module fsw_host_model (
  input  wire logic         clk,
  output fsw_pkg::fsw_cmd_s cmd
);
  // ****************************************
  // command driver
  // ****************************************
  initial cmd = '0;
  // one command per call; the answer is settled when the task returns
  task send(input logic [7:0] op, input logic [23:0] ad, input logic [7:0] dt);
    cmd = {1'b1, op, ad, dt};
    @(posedge clk);
    #1;
  endtask : send
  // inverted fields, so nothing downstream can lean on the last command
  task idle();
    cmd = {1'b0, ~cmd[39:0]};
    @(posedge clk);
    #1;
  endtask : idle
  // latch set always goes right ahead of a gated op
  task gated(input logic [7:0] op, input logic [23:0] ad, input logic [7:0] dt);
    send(8'h06, 24'h000000, 8'h00);
    send(op, ad, dt);
  endtask : gated
endmodule : fsw_host_model

/* verification/fsw_gate_assertions.sv */
// Purpose: port-level checks of status word and write gating
// Assumes: bench runs REG_CYCLES at 3, no abort during status writes
// Notes:   one clock domain, so default clocking and disable are used
`timescale 1ns/100ps
`include "fsw_params.svh"
module fsw_gate_chk #(
  parameter logic [7:0]  LATCH_SET_OP = 8'h06,
  parameter logic [7:0]  LATCH_CLR_OP = 8'h04,
  parameter logic [7:0]  STAT_RD_OP   = 8'h05,
  parameter logic [7:0]  SUSPEND_OP   = 8'h75,
  parameter logic [23:0] REG_CYCLES   = 24'd30
) (
  input wire logic               clk,
  input wire logic               resetn,
  input wire fsw_pkg::fsw_cmd_s  cmd,
  input wire logic               writeProtectN,
  input wire logic               bottomSelect,
  input wire logic               opAbort,
  input wire logic [7:0]         statusWord,
  input wire logic               quadIoEnable,
  input wire logic               statusReadValid,
  input wire logic [7:0]         statusReadData,
  input wire fsw_pkg::fsw_exec_s exec,
  input wire logic               cmdRefused
);
  // ****************************************
  // helpers and sequences
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [7:0] op;
  logic       busy;
  logic       write_enable_latch;
  logic       go;
  logic       gatedOp;
  assign op   = cmd.opcode;
  assign busy = statusWord[0];
  assign write_enable_latch  = statusWord[1];
  assign go   = cmd.valid && !busy;
  assign gatedOp = op inside {`FSW_OP_PAGE_PROG, `FSW_OP_QPROG_A, `FSW_OP_QPROG_B,
    `FSW_OP_SECT_A, `FSW_OP_SECT_B, `FSW_OP_HALF_BLK, `FSW_OP_BLK, `FSW_OP_CHIP_A,
    `FSW_OP_CHIP_B, `FSW_OP_STAT_WR, `FSW_OP_FUNC_WR, `FSW_OP_RDP_NV, `FSW_OP_ERDP_NV,
    `FSW_OP_IROW_ERASE, `FSW_OP_IROW_PROG, `FSW_OP_BOOT_WR};
  // a status write that the lock does not stop
  sequence wrsrTaken;
    go && op == `FSW_OP_STAT_WR && write_enable_latch && !(statusWord[7] && !writeProtectN) && !opAbort;
  endsequence
  // fixed length only holds because the bench keeps REG_CYCLES at 3
  sequence regBusy;
    (busy && !opAbort)[*3] ##1 !busy;
  endsequence
  // ****************************************
  // assertions
  // ****************************************
  reset_word_zero_a: assert property ($rose(resetn) |-> statusWord == 8'h00)
    else $error("status word not clear after reset");
  quad_mirror_a: assert property (quadIoEnable == statusWord[6])
    else $error("quad enable differs from status bit 6");
  latch_set_a: assert property (go && op == LATCH_SET_OP |=> write_enable_latch)
    else $error("latch not set");
  latch_clear_a: assert property (go && op == LATCH_CLR_OP |=> !write_enable_latch)
    else $error("latch not cleared");
  read_reply_a: assert property (cmd.valid && op == STAT_RD_OP |=> statusReadValid
    && statusReadData == $past(statusWord)) else $error("status read reply wrong");
  gate_refuse_a: assert property (go && gatedOp && !write_enable_latch |=> cmdRefused
    && !exec.valid && $stable(statusWord)) else $error("gated op ran without latch");
  busy_ignore_a: assert property (cmd.valid && busy && op == LATCH_SET_OP |=> cmdRefused)
    else $error("latch set taken while busy");
  status_write_cmd_keeps_a: assert property (wrsrTaken |=> write_enable_latch
    && statusWord[7:2] == $past(cmd.data[7:2])) else $error("status write result wrong");
  status_write_cmd_length_a: assert property (wrsrTaken |=> regBusy)
    else $error("status write busy span wrong");
  end_clears_a: assert property ($fell(busy) && !($past(cmd.valid)
    && $past(op) == SUSPEND_OP) |-> !write_enable_latch) else $error("latch kept after op end");
  lock_hold_a: assert property (go && op == `FSW_OP_STAT_WR && statusWord[7]
    && !writeProtectN |=> cmdRefused && $stable(statusWord[7:2]))
    else $error("locked word changed");
  chip_guard_a: assert property (go && op inside {`FSW_OP_CHIP_A, `FSW_OP_CHIP_B}
    && statusWord[5:2] != 4'h0 |=> cmdRefused && !exec.valid) else $error("chip erase ran");
  busy_start_a: assert property (exec.valid && exec.opcode inside {`FSW_OP_STAT_WR,
    `FSW_OP_PAGE_PROG, `FSW_OP_SECT_B} |-> busy) else $error("op started without busy");
endmodule : fsw_gate_chk

bind flash_status_write_gate fsw_gate_chk #(
  .LATCH_SET_OP(LATCH_SET_OP), .LATCH_CLR_OP(LATCH_CLR_OP), .STAT_RD_OP(STAT_RD_OP),
  .SUSPEND_OP(SUSPEND_OP), .REG_CYCLES(REG_CYCLES)
) u_fsw_gate_chk (
  .clk(clk), .resetn(resetn), .cmd(cmd), .writeProtectN(writeProtectN),
  .bottomSelect(bottomSelect), .opAbort(opAbort), .statusWord(statusWord),
  .quadIoEnable(quadIoEnable), .statusReadValid(statusReadValid),
  .statusReadData(statusReadData), .exec(exec), .cmdRefused(cmdRefused)
);

/* verification/tb_flash_status_write_gate.sv */
// Purpose: self-checking bench of the flash status and write gate
// Assumes: short op durations set through parameters
// Notes:   seed 15, random data and addresses among hand cases
`timescale 1ns/100ps
`include "fsw_params.svh"
module tb_flash_status_write_gate;
  // ****************************************
  // signals, tables, helpers
  // ****************************************
  logic               clk;
  logic               resetn;
  logic               writeProtectN;
  logic               bottomSelect;
  logic               opAbort;
  fsw_pkg::fsw_cmd_s  cmd;
  fsw_pkg::fsw_exec_s exec;
  logic [7:0]         statusWord;
  logic [7:0]         statusReadData;
  logic [7:0]         expW;
  logic [7:0]         d;
  logic [23:0]        a;
  logic               quadIoEnable;
  logic               statusReadValid;
  logic               cmdRefused;
  int                 badCount;
  int                 checks;
  int                 i;
  localparam logic [7:0] GATED [16] = '{8'h02, 8'h32, 8'h38, 8'hd7, 8'h20, 8'h52, 8'hd8,
    8'hc7, 8'h60, 8'h01, 8'h42, 8'h65, 8'h85, 8'h64, 8'h62, 8'h15};
  localparam logic [7:0]  ERASE [4] = '{8'h20, 8'h52, 8'hd8, 8'hc7};
  localparam logic [23:0] MASK [4]  = '{24'hfff000, 24'hff8000, 24'hff0000, 24'h000000};
  localparam logic [2:0]  SPAN [4]  = '{3'h2, 3'h3, 3'h4, 3'h5};

  fsw_host_model u_fsw_host_model (.clk(clk), .cmd(cmd));
  flash_status_write_gate #(.PROG_CYCLES(24'd8), .SECT_CYCLES(24'd5), .BLOCK_CYCLES(24'd6),
    .CHIP_CYCLES(24'd7), .REG_CYCLES(24'd3)) u_flash_status_write_gate (
    .clk(clk), .resetn(resetn), .cmd(cmd), .writeProtectN(writeProtectN),
    .bottomSelect(bottomSelect), .opAbort(opAbort), .statusWord(statusWord),
    .quadIoEnable(quadIoEnable), .statusReadValid(statusReadValid),
    .statusReadData(statusReadData), .exec(exec), .cmdRefused(cmdRefused));

  // value and flag comparisons; four-state equality so unknowns fail
  task cmp(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp)
    begin
      badCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task cmp1(input logic got, input logic exp);
    cmp({23'h0, got}, {23'h0, exp});
  endtask : cmp1
  // word after latch set plus status write; the lock refuses with latch left set
  function automatic logic [7:0] wrExp(logic [7:0] cur, logic [7:0] dt, logic wpN);
    if (cur[7] && !wpN)
      return cur | 8'h02;
    return {dt[7:2], 2'b11};
  endfunction : wrExp
  // bounded wait, since durations differ per op
  task waitReady();
    int n;
    n = 0;
    while (statusWord[0] !== 1'b0 && n < 100)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp1(statusWord[0], 1'b0);
  endtask : waitReady
  task giveVerdict();
    $display("checks=%0d mismatches=%0d", checks, badCount);
    if (badCount == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : giveVerdict

  // ****************************************
  // clock, watchdog, tests
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // whole run is roughly 120 cycles; this span of 5000 cycles is far beyond it
  initial
  begin
    #(40 * 5000);
    badCount++;
    giveVerdict();
  end
  initial
  begin
    resetn = 1'b0;
    writeProtectN = 1'b1;
    bottomSelect = 1'b0;
    opAbort = 1'b0;
    badCount = 0;
    checks = 0;
    d = 8'($urandom(15));
    repeat (10) @(posedge clk);
    #1 resetn = 1'b1;
    cmp(statusWord, 8'h00);
    cmp1(cmdRefused, 1'b0);
    $display("test reset done");
    // every gated opcode back to back with latch clear
    for (i = 0; i < 16; i++)
    begin
      u_fsw_host_model.send(GATED[i], 24'($urandom), 8'($urandom));
      cmp1(cmdRefused, 1'b1);
      cmp1(exec.valid, 1'b0);
    end
    u_fsw_host_model.send(8'hc0, 24'h000000, 8'($urandom));
    cmp1(exec.valid, 1'b1);
    cmp1(cmdRefused, 1'b0);
    u_fsw_host_model.send(8'h05, 24'h000000, 8'h00);
    cmp1(statusReadValid, 1'b1);
    cmp(statusReadData, 8'h00);
    u_fsw_host_model.send(8'h06, 24'h000000, 8'h00);
    cmp1(statusWord[1], 1'b1);
    u_fsw_host_model.send(8'h04, 24'h000000, 8'h00);
    cmp1(statusWord[1], 1'b0);
    u_fsw_host_model.idle();
    $display("test gating done");
    // status writes: lock set, lock refusal, random, then unlock
    for (i = 0; i < 6; i++)
    begin
      d = (i == 0) ? 8'h80 : (i == 5) ? 8'h00 : 8'($urandom);
      writeProtectN = (i == 5) || (i > 1 && 1'($urandom));
      expW = wrExp(statusWord, d, writeProtectN);
      u_fsw_host_model.gated(8'h01, 24'h000000, d);
      cmp(statusWord, expW);
      cmp1(quadIoEnable, expW[6]);
      cmp1(exec.valid, expW[0]);
      if (expW[0])
      begin
        u_fsw_host_model.send(8'h05, 24'h000000, 8'h00);
        cmp(statusReadData, expW);
        u_fsw_host_model.send(8'h06, 24'h000000, 8'h00);
        cmp1(cmdRefused, 1'b1);
      end
      else
        u_fsw_host_model.send(8'h04, 24'h000000, 8'h00);
      u_fsw_host_model.idle();
      cmp(statusWord, {expW[7:2], 2'b00});
    end
    $display("test status write done");
    // erase spans and target bases at random addresses
    for (i = 0; i < 4; i++)
    begin
      a = 24'($urandom);
      u_fsw_host_model.gated(ERASE[i], a, 8'h00);
      cmp1(exec.valid, 1'b1);
      cmp(exec.span, SPAN[i]);
      if (MASK[i] != 24'h0)
        cmp(exec.base, a & MASK[i]);
      u_fsw_host_model.idle();
      waitReady();
      cmp1(statusWord[1], 1'b0);
    end
    $display("test erase done");
    // one protected block at the end chosen by bottomSelect
    bottomSelect = 1'($urandom);
    u_fsw_host_model.gated(8'h01, 24'h000000, 8'h04);
    u_fsw_host_model.idle();
    waitReady();
    u_fsw_host_model.gated(8'hc7, 24'h000000, 8'h00);
    cmp1(cmdRefused, 1'b1);
    u_fsw_host_model.gated(8'h20, bottomSelect ? 24'h000123 : 24'hff0123, 8'h00);
    cmp1(cmdRefused, 1'b1);
    u_fsw_host_model.gated(8'h20, bottomSelect ? 24'hff0123 : 24'h000123, 8'h00);
    cmp1(exec.valid, 1'b1);
    u_fsw_host_model.idle();
    waitReady();
    u_fsw_host_model.gated(8'h01, 24'h000000, 8'h00);
    u_fsw_host_model.idle();
    waitReady();
    $display("test protection done");
    // program, suspend, resume, then abort from the array side
    u_fsw_host_model.gated(8'h02, 24'($urandom), 8'h5a);
    cmp1(statusWord[0], 1'b1);
    u_fsw_host_model.send(8'h75, 24'h000000, 8'h00);
    cmp1(statusWord[0], 1'b0);
    cmp1(cmdRefused, 1'b0);
    u_fsw_host_model.send(8'h7a, 24'h000000, 8'h00);
    cmp1(statusWord[0], 1'b1);
    u_fsw_host_model.idle();
    opAbort = 1'b1;
    @(posedge clk);
    #1 opAbort = 1'b0;
    cmp(statusWord[1:0], 2'b00);
    $display("test suspend abort done");
    // software reset in mid-erase drops busy and latch at once
    u_fsw_host_model.gated(8'h20, 24'($urandom), 8'h00);
    u_fsw_host_model.send(8'h99, 24'h000000, 8'h00);
    cmp1(cmdRefused, 1'b0);
    cmp(statusWord[1:0], 2'b00);
    u_fsw_host_model.idle();
    $display("test reset command done");
    giveVerdict();
  end
endmodule : tb_flash_status_write_gate
